/* File: pkg/cbt_defines.vh */
// register map, field positions, reset values and timing counts for the bit-timing block
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH
`define CBT_OFF_CTRL      12'h000
`define CBT_OFF_STATUS    12'h004
`define CBT_OFF_BTR0      12'h008
`define CBT_OFF_BTR1      12'h00C
// segments register index; its byte address is four times this
`define CBT_IDX_BTR1      3
`define CBT_OFF_RFLG      12'h010
`define CBT_OFF_RIER      12'h014
`define CBT_OFF_SAMPLE    12'h018
`define CBT_CTRL_INIT_MODE_REQUEST   0
`define CBT_CTRL_CLOCK_SOURCE_SELECT   1
`define CBT_SJW_HI        7
`define CBT_SJW_LO        6
`define CBT_BRP_HI        5
`define CBT_BRP_LO        0
`define CBT_TRIPLE_SAMPLE_SELECT_BIT      7
`define CBT_SECOND_TIME_SEGMENT_HI      6
`define CBT_SECOND_TIME_SEGMENT_LO      4
`define CBT_FIRST_TIME_SEGMENT_HI      3
`define CBT_FIRST_TIME_SEGMENT_LO      0
`define CBT_FLG_BITERR    0
`define CBT_FLG_EDGE      1
`define CBT_BTR0_RESET    8'h00
`define CBT_BTR1_RESET    8'h00
`define CBT_CTRL_RESET    2'h1
`define CBT_ACK_DELAY     4'h2
`define CBT_NFLAGS        2
`endif

/* File: rtl/cbt_tq_gen.v */
// time-quantum enable divider with selectable clock source
`timescale 1ns/1ps
module cbt_tq_gen
(
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       run_i,
  input  wire       clk_src_i,
  input  wire       osc_tick_i,
  input  wire [5:0] prescale_i,
  output reg        tq_o
);
  reg  [5:0] cnt_q;
  wire       src_tick;

  // bus clock ticks every cycle, oscillator only on its enable
  assign src_tick = clk_src_i ? 1'b1 : osc_tick_i;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_q <= 6'h00;
      tq_o  <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_q <= 6'h00;
      tq_o  <= 1'b0;
    end
    else if (src_tick)
    begin
      // divide by code plus one
      if (cnt_q >= prescale_i)
      begin
        cnt_q <= 6'h00;
        tq_o  <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 6'h01;
        tq_o  <= 1'b0;
      end
    end
    else
      tq_o <= 1'b0;
  end
endmodule // cbt_tq_gen

/* File: rtl/cbt_bit_timing.v */
// CAN bit-timing configuration, bit-time engine, receiver flags, APB slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "cbt_defines.vh"
module cbt_bit_timing
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        osc_tick_i,
  input  wire        rx_pin_i,
  output reg         rx_bit_o,
  output reg         rx_bit_valid_o,
  output reg         irq_o
);
  localparam [1:0] ST_SYNC = 2'd0;
  localparam [1:0] ST_SEG1 = 2'd1;
  localparam [1:0] ST_SEG2 = 2'd2;

  reg  [1:0]  ctrl_q;
  reg  [3:0]  ack_cnt_q;
  reg         init_ack_q;
  reg  [7:0]  btr0_q;
  reg  [7:0]  btr1_q;
  reg  [1:0]  rflg_q;
  reg  [1:0]  rier_q;
  reg  [2:0]  rx_sync_q;
  reg         rx_q;
  reg  [1:0]  state_q;
  reg  [4:0]  tq_cnt_q;
  reg  [2:0]  triple_sample_select_q;
  reg  [31:0] nsample_q;
  reg         biterr_q;
  reg         edge_q;
  wire        init_mode;
  wire        tq;
  wire        wr_en;
  wire        rd_en;
  wire [4:0]  seg1_len;
  wire [4:0]  seg2_len;
  wire [2:0]  sjw_len;
  wire        maj;
  wire [1:0]  flg_set;
  wire [1:0]  flg_clr;
  reg  [31:0] rdata;
  reg         hit;

  // init mode only when both request and acknowledge are set
  assign init_mode = ctrl_q[`CBT_CTRL_INIT_MODE_REQUEST] & init_ack_q;
  // write lands on the ready edge, while the master still holds its data
  assign wr_en     = psel_i & penable_i & pwrite_i & pready_o;
  assign rd_en     = psel_i & penable_i & ~pwrite_i & ~pready_o;
  assign seg1_len  = {1'b0, btr1_q[`CBT_FIRST_TIME_SEGMENT_HI:`CBT_FIRST_TIME_SEGMENT_LO]} + 5'd1;
  assign seg2_len  = {2'b00, btr1_q[`CBT_SECOND_TIME_SEGMENT_HI:`CBT_SECOND_TIME_SEGMENT_LO]} + 5'd1;
  assign sjw_len   = {1'b0, btr0_q[`CBT_SJW_HI:`CBT_SJW_LO]} + 3'd1;
  assign maj       = (triple_sample_select_q[0] & triple_sample_select_q[1]) | (triple_sample_select_q[0] & rx_q) |
                     (triple_sample_select_q[1] & rx_q);

  cbt_tq_gen u_tq
  (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .run_i      (~init_mode),
    .clk_src_i  (ctrl_q[`CBT_CTRL_CLOCK_SOURCE_SELECT]),
    .osc_tick_i (osc_tick_i),
    .prescale_i (btr0_q[`CBT_BRP_HI:`CBT_BRP_LO]),
    .tq_o       (tq)
  );

  // control and init acknowledge handshake, ack follows request after a delay
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_q     <= `CBT_CTRL_RESET;
      ack_cnt_q  <= 4'h0;
      init_ack_q <= 1'b1;
    end
    else
    begin
      if (wr_en && paddr_i == `CBT_OFF_CTRL)
        ctrl_q <= pwdata_i[1:0];
      if (ctrl_q[`CBT_CTRL_INIT_MODE_REQUEST] == init_ack_q)
        ack_cnt_q <= 4'h0;
      else if (ack_cnt_q == `CBT_ACK_DELAY)
      begin
        ack_cnt_q  <= 4'h0;
        init_ack_q <= ctrl_q[`CBT_CTRL_INIT_MODE_REQUEST];
      end
      else
        ack_cnt_q <= ack_cnt_q + 4'h1;
    end
  end

  // timing registers locked outside init mode
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      btr0_q <= `CBT_BTR0_RESET;
      btr1_q <= `CBT_BTR1_RESET;
    end
    else if (wr_en && init_mode)
    begin
      if (paddr_i == `CBT_OFF_BTR0)
        btr0_q <= pwdata_i[7:0];
      else if (paddr_i == `CBT_OFF_BTR1)
        btr1_q <= pwdata_i[7:0];
    end
  end

  // rx pin synchroniser, change counts once stages two and three agree
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_sync_q <= 3'b111;
      rx_q      <= 1'b1;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin_i};
      if (rx_sync_q[1] == rx_sync_q[2])
        rx_q <= rx_sync_q[2];
    end
  end

  // bit-time engine: sync, seg1, sample point, seg2
  // resync limited to jump width; hard sync not modelled, edges only shift phase
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q        <= ST_SYNC;
      tq_cnt_q       <= 5'd0;
      triple_sample_select_q         <= 3'b111;
      rx_bit_o       <= 1'b1;
      rx_bit_valid_o <= 1'b0;
      nsample_q      <= 32'h0000_0000;
      biterr_q       <= 1'b0;
      edge_q         <= 1'b1;
    end
    else
    begin
      rx_bit_valid_o <= 1'b0;
      biterr_q       <= 1'b0;
      if (init_mode)
      begin
        state_q  <= ST_SYNC;
        tq_cnt_q <= 5'd0;
      end
      else if (tq)
      begin
        triple_sample_select_q <= {triple_sample_select_q[1:0], rx_q};
        edge_q <= rx_q;
        case (state_q)
          ST_SYNC:
          begin
            // one-quantum sync segment starts each bit, except after an early-edge resync in seg2, which goes straight to seg1
            state_q  <= ST_SEG1;
            tq_cnt_q <= 5'd0;
          end
          ST_SEG1:
          begin
            if (edge_q != rx_q && tq_cnt_q == 5'd0 && sjw_len != 3'd0)
              tq_cnt_q <= 5'd0;
            else if (tq_cnt_q + 5'd1 >= seg1_len)
            begin
              // sample point at end of seg1
              state_q  <= ST_SEG2;
              tq_cnt_q <= 5'd0;
              // triple sampling uses last three quanta of seg1
              if (btr1_q[`CBT_TRIPLE_SAMPLE_SELECT_BIT])
              begin
                rx_bit_o <= maj;
                biterr_q <= ~((triple_sample_select_q[0] == rx_q) && (triple_sample_select_q[1] == rx_q));
              end
              else
                rx_bit_o <= rx_q;
              rx_bit_valid_o <= 1'b1;
              nsample_q      <= nsample_q + 32'h0000_0001;
            end
            else
              tq_cnt_q <= tq_cnt_q + 5'd1;
          end
          ST_SEG2:
          begin
            // early edge shortens seg2 by up to jump width
            if (edge_q != rx_q && seg2_len - tq_cnt_q <= {2'b00, sjw_len})
            begin
              state_q  <= ST_SEG1;
              tq_cnt_q <= 5'd0;
            end
            // bit = 1 + seg1 + seg2 quanta of prescale clocks
            else if (tq_cnt_q + 5'd1 >= seg2_len)
            begin
              state_q  <= ST_SYNC;
              tq_cnt_q <= 5'd0;
            end
            else
              tq_cnt_q <= tq_cnt_q + 5'd1;
          end
          default:
          begin
            state_q  <= ST_SYNC;
            tq_cnt_q <= 5'd0;
          end
        endcase
      end
    end
  end

  // receiver flags: set events are sampling disagreement and rx edge
  assign flg_set = {tq & (edge_q != rx_q) & ~init_mode, biterr_q};
  assign flg_clr = (wr_en && paddr_i == `CBT_OFF_RFLG && !init_mode) ?
                   pwdata_i[1:0] : 2'b00;

  genvar gi;
  generate
    for (gi = 0; gi < `CBT_NFLAGS; gi = gi + 1)
    begin : g_flag
      always @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
          rflg_q[gi] <= 1'b0;
        else if (init_mode)
          rflg_q[gi] <= 1'b0;
        // set wins, so clear only takes once the cause has gone
        else if (flg_set[gi])
          rflg_q[gi] <= 1'b1;
        else if (flg_clr[gi])
          rflg_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rier_q <= 2'b00;
      irq_o  <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr_i == `CBT_OFF_RIER)
        rier_q <= pwdata_i[1:0];
      irq_o <= |(rflg_q & rier_q);
    end
  end

  // read mux and decode
  always @*
  begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    if (paddr_i == `CBT_OFF_CTRL)
      rdata = {30'h0000_0000, ctrl_q};
    else if (paddr_i == `CBT_OFF_STATUS)
      rdata = {29'h0000_0000, state_q, init_ack_q};
    else if (paddr_i == `CBT_OFF_BTR0)
      rdata = {24'h00_0000, btr0_q};
    else if (paddr_i == `CBT_OFF_BTR1)
      rdata = {24'h00_0000, btr1_q};
    else if (paddr_i == `CBT_OFF_RFLG)
      rdata = {30'h0000_0000, rflg_q};
    else if (paddr_i == `CBT_OFF_RIER)
      rdata = {30'h0000_0000, rier_q};
    else if (paddr_i == `CBT_OFF_SAMPLE)
      rdata = nsample_q;
    else
      hit = 1'b0;
  end

  // one wait state: pready one cycle after access phase starts
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
      if (rd_en)
        prdata_o <= rdata;
    end
  end
endmodule // cbt_bit_timing

/* File: tb/cbt_bit_timing_sva.sv */
// port-level assertions for the bit-timing block
`timescale 1ns/1ps
module cbt_bit_timing_sva
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rx_bit_o,
  input wire logic        rx_bit_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_rd;
    pready_o && !pwrite_i;
  endsequence
  a_ready_one_wait: assert property (s_acc |=> pready_o)
    else $error("ready missing after one wait state");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_unmapped: assert property (pready_o && paddr_i[1:0] == 2'h0
    |-> pslverr_o == (paddr_i > 12'h018)) else $error("error flag wrong for address");
  a_reg_upper_zero: assert property (s_rd and paddr_i < 12'h018
    |-> prdata_o[31:8] == 24'h00_0000) else $error("upper read bits not zero");
  a_sample_pulse: assert property (rx_bit_valid_o |=> !rx_bit_valid_o)
    else $error("sample pulse too long");
  a_bit_at_sample: assert property (!$stable(rx_bit_o) |-> rx_bit_valid_o)
    else $error("received bit moved off the sample point");
endmodule // cbt_bit_timing_sva
bind cbt_bit_timing cbt_bit_timing_sva chk (.clk_i(clk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .rx_bit_o(rx_bit_o), .rx_bit_valid_o(rx_bit_valid_o));

/* File: tb/cbt_can_node.sv */
// far-side bus node model driving the receive pin
`timescale 1ns/1ps
module cbt_can_node
(
  input  wire logic        clk_i,
  input  wire logic        send_i,
  input  wire logic [7:0]  bits_i,
  input  wire logic [15:0] bit_cyc_i,
  output logic             bus_o,
  output logic             busy_o
);
  // idle bus is recessive, so a released line reads one
  initial
  begin
    bus_o = 1'b1;
    busy_o = 1'b0;
  end
  always @(posedge clk_i)
    if (send_i)
    begin
      busy_o <= 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
        bus_o <= bits_i[i];
        repeat (bit_cyc_i) @(posedge clk_i);
      end
      bus_o <= 1'b1;
      busy_o <= 1'b0;
    end
endmodule // cbt_can_node

/* File: tb/can_bit_timing_config_bench.sv */
// self-checking bench for the bit-timing block
`timescale 1ns/1ps
`include "cbt_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module can_bit_timing_config_bench;
  logic        clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic        osc_tick_i = 0, send = 0, err, pready_o, pslverr_o, busy;
  logic        rx_pin_i, rx_bit_o, rx_bit_valid_o, irq_o;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [15:0] bit_cyc = 16'h0001;
  int          errors = 0, compares = 0, n, p, s1, s2, j, base;
  always #20 clk_i = ~clk_i;
  // oscillator enable at half the bus clock rate
  always @(posedge clk_i) osc_tick_i <= ~osc_tick_i;
  cbt_bit_timing dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .osc_tick_i(osc_tick_i), .rx_pin_i(rx_pin_i), .rx_bit_o(rx_bit_o),
    .rx_bit_valid_o(rx_bit_valid_o), .irq_o(irq_o));
  cbt_can_node node (.clk_i(clk_i), .send_i(send), .bits_i(8'h00), .bit_cyc_i(bit_cyc),
    .bus_o(rx_pin_i), .busy_o(busy));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // ack trails the request by a few cycles, so poll status
  task automatic set_init(input logic r, input logic src);
    apb(1, `CBT_OFF_CTRL, {30'h0, src, r});
    // read status at least once, the write leaves stale read data behind
    apb(0, `CBT_OFF_STATUS, 0);
    for (int k = 0; k < 20 && rd[0] !== r; k++) apb(0, `CBT_OFF_STATUS, 0);
    `CHK(rd[0], r)
  endtask
  task automatic measure;
    @(posedge clk_i iff rx_bit_valid_o === 1'b1);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rx_bit_valid_o !== 1'b1);
  endtask
  function automatic int bit_len(int pc, int c1, int c2, int src);
    return (pc + 1) * (3 + c1 + c2) * (src ? 1 : 2);
  endfunction
  task automatic test_done;
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    test_done;
  end
  initial
  begin
    void'($urandom(32'haf3d));
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(0, `CBT_OFF_CTRL, 0);
    `CHK(rd, 32'h0000_0001)
    apb(0, `CBT_OFF_BTR0, 0);
    `CHK(rd, 32'h0000_0000)
    apb(0, `CBT_OFF_BTR1, 0);
    `CHK(rd, 32'h0000_0000)
    apb(0, 12'h01C, 0);
    `CHK(err, 1'b1)
    for (int src = 0; src < 2; src++)
    begin
      j = $urandom_range(3);
      p = src ? 0 : $urandom_range(3);
      s1 = src ? 15 : $urandom_range(15, 2);
      s2 = src ? 7 : $urandom_range(7, 1);
      set_init(1, src);
      apb(1, `CBT_OFF_BTR0, {24'h0, j[1:0], p[5:0]});
      // single sampling, first segment kept at three quanta or more
      apb(1, `CBT_OFF_BTR1, {24'h0, 1'b0, s2[2:0], s1[3:0]});
      apb(0, `CBT_OFF_BTR0, 0);
      `CHK(rd, {24'h0, j[1:0], p[5:0]})
      apb(0, `CBT_OFF_BTR1, 0);
      `CHK(rd, {24'h0, 1'b0, s2[2:0], s1[3:0]})
      set_init(0, src);
      apb(1, `CBT_OFF_BTR0, 32'h0000_00FF);
      apb(0, `CBT_OFF_BTR0, 0);
      `CHK(rd, {24'h0, j[1:0], p[5:0]})
      measure;
      measure;
      `CHK(n, bit_len(p, s1, s2, src))
    end
    bit_cyc <= n[15:0];
    for (int t = 0; t < 2; t++)
    begin
      if (t == 1)
      begin
        set_init(1, 1);
        // majority of three, first segment well above two quanta
        apb(1, `CBT_OFF_BTR1, 32'h0000_00FF);
        set_init(0, 1);
      end
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      repeat (3) measure;
      `CHK(rx_bit_o, 1'b0)
      wait (busy === 1'b0);
      repeat (2) measure;
      `CHK(rx_bit_o, 1'b1)
      apb(0, `CBT_OFF_SAMPLE, 0);
      base = rd;
      measure;
      apb(0, `CBT_OFF_SAMPLE, 0);
      `CHK(rd - base, 32'h0000_0002)
    end
    apb(1, `CBT_OFF_RIER, 2);
    apb(0, `CBT_OFF_RFLG, 0);
    `CHK(rd[1], 1'b1)
    `CHK(irq_o, 1'b1)
    apb(1, `CBT_OFF_RIER, 0);
    apb(0, `CBT_OFF_RFLG, 0);
    `CHK(irq_o, 1'b0)
    apb(1, `CBT_OFF_RIER, 2);
    apb(1, `CBT_OFF_RFLG, 0);
    apb(0, `CBT_OFF_RFLG, 0);
    `CHK(rd[1], 1'b1)
    apb(1, `CBT_OFF_RFLG, 2);
    apb(0, `CBT_OFF_RFLG, 0);
    `CHK(rd[1], 1'b0)
    `CHK(irq_o, 1'b0)
    test_done;
  end
endmodule // can_bit_timing_config_bench
